// file: eq_ctrl_map.vh
// Register offsets, field positions, reset values and link framing for the equalizer control bank.
`ifndef EQ_CTRL_MAP_VH
`define EQ_CTRL_MAP_VH

// ****************************************************************
// Register offsets (7-bit link address)
// ****************************************************************
`define GENERAL_CONTROL_ADDR        7'h00
`define OUTPUT_DRIVER_SETUP_ADDR    7'h01
`define LAUNCH_AMPLITUDE_SETUP_ADDR 7'h02

// ****************************************************************
// General control fields
// ****************************************************************
`define GC_CARRIER_BIT  7
`define GC_MUTE_BIT     6
`define GC_BYPASS_BIT   5
`define GC_SLEEP_HI     4
`define GC_SLEEP_LO     3
`define GC_RSVD_BIT     2
`define GC_MASTER_BIT   1
`define GC_ACQ_BIT      0
`define SLEEP_ENABLED   2'h0
`define SLEEP_AUTO      2'h1
`define SLEEP_FORCED    2'h2
`define MUTE_RESET      1'h0
`define BYPASS_RESET    1'h0
`define SLEEP_RESET     2'h1
`define GC_RSVD_RESET   1'h0
`define PD_RESET        1'h1

// ****************************************************************
// Output driver fields
// ****************************************************************
`define OD_SWING_HI     7
`define OD_SWING_LO     6
`define OD_OFFSET_HI    5
`define OD_OFFSET_LO    4
`define OD_DEEMPH_EN    3
`define OD_LEVEL_HI     2
`define OD_LEVEL_LO     1
`define SWING_RESET     2'h2
`define OFFSET_RESET    2'h2
`define DEEMPH_EN_RESET 1'h0
`define LEVEL_RESET     2'h1

// ****************************************************************
// Launch amplitude fields
// ****************************************************************
`define LA_OPT_BIT      7
`define LA_RSVD_HI      6
`define LA_OPT_RESET    1'h0
`define LA_RSVD_RESET   7'h68

// ****************************************************************
// Link framing
// ****************************************************************
`define FRAME_BITS      5'h10
`define HEADER_BITS     5'h08

`endif

// file: spi_frame_port.v
// Serial link front end: samples the link pins, frames 16-bit transfers and shifts read data out.
`timescale 1ns/100ps
`default_nettype none
`include "eq_ctrl_map.vh"

module spi_frame_port (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       sclk_i,
  input  wire       ss_n_i,
  input  wire       mosi_i,
  output wire       miso_o,
  output wire       miso_oe_n_o,
  output wire [6:0] rd_addr_o,
  input  wire [7:0] rd_data_i,
  output reg        wr_o,
  output reg  [6:0] wr_addr_o,
  output reg  [7:0] wr_data_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [2:0]  meta_reg;
  reg [2:0]  sync_reg;
  reg        sclk_old_reg;
  reg [4:0]  cnt_reg;
  reg [14:0] sh_reg;
  reg [7:0]  tx_reg;
  reg        miso_reg;

  // Synchronised pin levels and the link clock edges they reveal while selected.
  wire sclk_s = sync_reg[2];
  wire ss_n_s = sync_reg[1];
  wire mosi_s = sync_reg[0];
  wire rise   = ~ss_n_s & sclk_s & ~sclk_old_reg;
  wire fall   = ~ss_n_s & ~sclk_s & sclk_old_reg;

  // Two flops per pin; only the second stage feeds logic.
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_reg     <= 3'h3;
      sync_reg     <= 3'h3;
      sclk_old_reg <= 1'h0;
    end else begin
      meta_reg     <= {sclk_i, ss_n_i, mosi_i};
      sync_reg     <= meta_reg;
      sclk_old_reg <= sync_reg[2];
    end
  end

  // ****************************************************************
  // Framing and shifting
  // ****************************************************************
  // The read address is the header as it arrives, so it is valid once eight bits are in.
  assign rd_addr_o   = sh_reg[6:0];
  assign miso_o      = miso_reg;
  assign miso_oe_n_o = ss_n_s;

  // Bits arrive MSB first on rising edges; read data leaves on falling edges after the header.
  // A frame cut short by deselect is dropped, so a partial write never lands.
  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg   <= 5'h00;
      sh_reg    <= 15'h0000;
      tx_reg    <= 8'h00;
      miso_reg  <= 1'h0;
      wr_o      <= 1'h0;
      wr_addr_o <= 7'h00;
      wr_data_o <= 8'h00;
    end else begin
      wr_o <= 1'h0;
      if (ss_n_s) begin
        cnt_reg  <= 5'h00;
        miso_reg <= 1'h0;
      end else if (rise && cnt_reg < `FRAME_BITS) begin
        sh_reg  <= {sh_reg[13:0], mosi_s};
        cnt_reg <= cnt_reg + 5'h01;
        if (cnt_reg == `FRAME_BITS - 5'h01) begin
          wr_o      <= ~sh_reg[14];
          wr_addr_o <= sh_reg[13:7];
          wr_data_o <= {sh_reg[6:0], mosi_s};
        end
      end else if (fall && cnt_reg == `HEADER_BITS) begin
        miso_reg <= rd_data_i[7];
        tx_reg   <= {rd_data_i[6:0], 1'h0};
      end else if (fall && cnt_reg > `HEADER_BITS && cnt_reg < `FRAME_BITS) begin
        miso_reg <= tx_reg[7];
        tx_reg   <= {tx_reg[6:0], 1'h0};
      end
    end
  end

endmodule
`default_nettype wire

// file: equalizer_control_registers.v
// Control register bank of the cable equalizer: general control, output driver and launch amplitude.
//
// Functional notes
// - Bit 7 of general control reads the carrier flag, 1 when a carrier is present.
// - Mute bit 6 mutes the outputs, bypass bit 5 bypasses the equalizer, mute beats bypass, both reset to 0.
// - Sleep code 00 keeps the equalizer on, 01 (default) sleeps without input, 10 forces power-down, 11 reserved.
// - Whenever sleep is in effect it overrides mute and bypass.
// - Writing 1 to bit 1 resets every register to default and restarts acquisition, then clears itself.
// - Writing 1 to bit 0 restarts acquisition only, leaves registers alone, then clears itself.
// - Output driver bits 7:6 pick the swing 400/600/700/800 mV, reset value 10.
// - Output driver bits 5:4 pick the common-mode 0.8/1.0/1.2 V or supply-referenced, reset value 10.
// - Output driver bit 3 enables de-emphasis, reset value 0.
// - Output driver bits 2:1 pick de-emphasis 0/3/5/7 dB, reset value 01.
// - Launch amplitude bit 7 selects 800 mV launch at 0 (default) or 6 dB attenuated input at 1.
`timescale 1ns/100ps
`default_nettype none
`include "eq_ctrl_map.vh"

module equalizer_control_registers (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       sclk_i,
  input  wire       ss_n_i,
  input  wire       mosi_i,
  output wire       miso_o,
  output wire       miso_oe_n_o,
  input  wire       carrier_detect_i,
  output wire       mute_o,
  output wire       bypass_o,
  output wire       power_down_o,
  output reg        acq_restart_o,
  output wire [1:0] output_swing_voltage_o,
  output wire [1:0] output_offset_voltage_o,
  output wire       deemph_enable_o,
  output wire [1:0] deemph_level_o,
  output wire       launch_atten_opt_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg        carrier_meta_reg;
  reg        carrier_reg;
  reg        mute_reg;
  reg        bypass_reg;
  reg  [1:0] sleep_reg;
  reg        gc_rsvd_reg;
  reg  [1:0] swing_reg;
  reg  [1:0] offset_reg;
  reg        deemph_en_reg;
  reg  [1:0] level_reg;
  reg        la_opt_reg;
  reg  [6:0] la_rsvd_reg;
  reg  [7:0] rd_data;
  reg        sleeping;
  reg        power_down_reg;
  reg        mute_out_reg;
  reg        bypass_out_reg;
  wire       wr;
  wire [6:0] wr_addr;
  wire [7:0] wr_data;
  wire [6:0] rd_addr;
  wire       gc_wr;
  wire       master_rst;
  wire       acq_rst;

  // ****************************************************************
  // Link front end
  // ****************************************************************
  spi_frame_port u_port (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .sclk_i      (sclk_i),
    .ss_n_i      (ss_n_i),
    .mosi_i      (mosi_i),
    .miso_o      (miso_o),
    .miso_oe_n_o (miso_oe_n_o),
    .rd_addr_o   (rd_addr),
    .rd_data_i   (rd_data),
    .wr_o        (wr),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data)
  );

  // ****************************************************************
  // Carrier flag synchroniser
  // ****************************************************************
  // The carrier comes from the analog core, so it is resynchronised before use.
  always @(posedge clk_i) begin
    if (srst_i) begin
      carrier_meta_reg <= 1'h0;
      carrier_reg      <= 1'h0;
    end else begin
      carrier_meta_reg <= carrier_detect_i;
      carrier_reg      <= carrier_meta_reg;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Decode of a landed frame; the two reset bits of general control act only as pulses.
  assign gc_wr      = wr && (wr_addr == `GENERAL_CONTROL_ADDR);
  assign master_rst = gc_wr && wr_data[`GC_MASTER_BIT];
  assign acq_rst    = gc_wr && wr_data[`GC_ACQ_BIT];

  // Master reset takes precedence over the rest of the same write, so a frame with
  // bit 1 set leaves every field at its default; the two reset bits are never stored.
  always @(posedge clk_i) begin
    if (srst_i || master_rst) begin
      mute_reg      <= `MUTE_RESET;
      bypass_reg    <= `BYPASS_RESET;
      sleep_reg     <= `SLEEP_RESET;
      gc_rsvd_reg   <= `GC_RSVD_RESET;
      swing_reg     <= `SWING_RESET;
      offset_reg    <= `OFFSET_RESET;
      deemph_en_reg <= `DEEMPH_EN_RESET;
      level_reg     <= `LEVEL_RESET;
      la_opt_reg    <= `LA_OPT_RESET;
      la_rsvd_reg   <= `LA_RSVD_RESET;
    end else if (wr) begin
      case (wr_addr)
        `GENERAL_CONTROL_ADDR: begin
          // Carrier bit is not written; it always mirrors the core.
          mute_reg    <= wr_data[`GC_MUTE_BIT];
          bypass_reg  <= wr_data[`GC_BYPASS_BIT];
          sleep_reg   <= wr_data[`GC_SLEEP_HI:`GC_SLEEP_LO];
          gc_rsvd_reg <= wr_data[`GC_RSVD_BIT];
        end
        `OUTPUT_DRIVER_SETUP_ADDR: begin
          // Bit 0 is read-only zero and is dropped here.
          swing_reg     <= wr_data[`OD_SWING_HI:`OD_SWING_LO];
          offset_reg    <= wr_data[`OD_OFFSET_HI:`OD_OFFSET_LO];
          deemph_en_reg <= wr_data[`OD_DEEMPH_EN];
          level_reg     <= wr_data[`OD_LEVEL_HI:`OD_LEVEL_LO];
        end
        `LAUNCH_AMPLITUDE_SETUP_ADDR: begin
          la_opt_reg  <= wr_data[`LA_OPT_BIT];
          la_rsvd_reg <= wr_data[`LA_RSVD_HI:0];
        end
        default: begin
          la_rsvd_reg <= la_rsvd_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // Acquisition restart
  // ****************************************************************
  // One-cycle pulse per restart write, held high through reset; the self-clearing bits exist only as this pulse.
  always @(posedge clk_i) begin
    if (srst_i) begin
      acq_restart_o <= 1'h1;
    end else begin
      acq_restart_o <= master_rst | acq_rst;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Unmapped addresses read zero; self-clearing and reserved driver bits read zero.
  always @* begin
    case (rd_addr)
      `GENERAL_CONTROL_ADDR: begin
        rd_data = {carrier_reg, mute_reg, bypass_reg, sleep_reg, gc_rsvd_reg, 2'h0};
      end
      `OUTPUT_DRIVER_SETUP_ADDR: begin
        rd_data = {swing_reg, offset_reg, deemph_en_reg, level_reg, 1'h0};
      end
      `LAUNCH_AMPLITUDE_SETUP_ADDR: begin
        rd_data = {la_opt_reg, la_rsvd_reg};
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // ****************************************************************
  // Core controls
  // ****************************************************************
  // Reserved sleep code 11 is treated like auto sleep, the least surprising choice.
  always @* begin
    case (sleep_reg)
      `SLEEP_ENABLED: begin
        sleeping = 1'h0;
      end
      `SLEEP_FORCED: begin
        sleeping = 1'h1;
      end
      default: begin
        sleeping = ~carrier_reg;
      end
    endcase
  end

  // Sleep masks mute and bypass, and mute masks bypass. The three levels are registered
  // so that the analog core never sees a glitch while the carrier flag or a field changes;
  // the price is one clock of latency, far below the length of any link frame.
  always @(posedge clk_i) begin
    if (srst_i) begin
      power_down_reg <= `PD_RESET;
      mute_out_reg   <= `MUTE_RESET;
      bypass_out_reg <= `BYPASS_RESET;
    end else begin
      power_down_reg <= sleeping;
      mute_out_reg   <= mute_reg & ~sleeping;
      bypass_out_reg <= bypass_reg & ~mute_reg & ~sleeping;
    end
  end

  // The stored levels and fields go straight to the core.
  assign power_down_o            = power_down_reg;
  assign mute_o                  = mute_out_reg;
  assign bypass_o                = bypass_out_reg;
  assign output_swing_voltage_o  = swing_reg;
  assign output_offset_voltage_o = offset_reg;
  assign deemph_enable_o         = deemph_en_reg;
  assign deemph_level_o          = level_reg;
  assign launch_atten_opt_o      = la_opt_reg;

endmodule
`default_nettype wire

// file: equalizer_control_registers_assertions.sv
// Concurrent checks on the ports of the equalizer control register bank.
`timescale 1ns/100ps
`default_nettype none
module equalizer_control_registers_assertions (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       sclk_i,
  input wire logic       ss_n_i,
  input wire logic       mosi_i,
  input wire logic       miso_o,
  input wire logic       miso_oe_n_o,
  input wire logic       carrier_detect_i,
  input wire logic       mute_o,
  input wire logic       bypass_o,
  input wire logic       power_down_o,
  input wire logic       acq_restart_o,
  input wire logic [1:0] output_swing_voltage_o,
  input wire logic [1:0] output_offset_voltage_o,
  input wire logic       deemph_enable_o,
  input wire logic [1:0] deemph_level_o,
  input wire logic       launch_atten_opt_o
);
  // ****************
  // Port checks
  // ****************
  // One clock domain, so reset aborts every attempt unless a check overrides it.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  reset_dflt_a:
    assert property (disable iff (1'b0) srst_i |=> acq_restart_o && !mute_o && !bypass_o && !deemph_enable_o
      && output_swing_voltage_o == 2'h2 && output_offset_voltage_o == 2'h2 && deemph_level_o == 2'h1
      && !launch_atten_opt_o && power_down_o) else $error("defaults missing after reset");
  mute_sleep_a:
    assert property (mute_o |-> !power_down_o) else $error("mute active while asleep");
  bypass_prio_a:
    assert property (bypass_o |-> !mute_o && !power_down_o) else $error("bypass beat mute or sleep");
  acq_pulse_a:
    assert property (acq_restart_o |=> !acq_restart_o) else $error("restart pulse too long");
  acq_cause_a:
    assert property ($rose(acq_restart_o) |-> !$past(ss_n_i, 8)) else $error("restart without a frame");
  drv_hold_a:
    assert property (ss_n_i [*8] |=> $stable({output_swing_voltage_o, output_offset_voltage_o,
      deemph_enable_o, deemph_level_o})) else $error("driver setup changed while idle");
  launch_hold_a:
    assert property (ss_n_i [*8] |=> $stable(launch_atten_opt_o)) else $error("launch setting changed idle");
  miso_idle_a:
    assert property (ss_n_i [*4] |-> miso_oe_n_o && !miso_o) else $error("data out driven while idle");
endmodule
`default_nettype wire

// file: spi_host_model.sv
// Link host model that sends 16-bit mode-0 frames and collects read data.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output var  logic sclk_o,
  output var  logic ss_n_o,
  output var  logic mosi_o
);
  // ****************
  // Frame driver
  // ****************
  // The link clock idles low and only runs inside a frame.
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Half period of 4 system clocks gives 160 ns, a 320 ns link period; data out is sampled on rises 9 to 16.
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    ss_n_o = 1'b0;
    for (int b = 15; b >= 0; b--) begin
      mosi_o = tx[b];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      if (b < 8) rx = {rx[6:0], miso_i};
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    ss_n_o = 1'b1;
    mosi_o = ~mosi_o; // A released line must not keep showing the last bit.
    repeat (8) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: equalizer_control_registers_tb.sv
// Self-checking bench for the equalizer control register bank.
`timescale 1ns/100ps
`default_nettype none
module equalizer_control_registers_tb;
  logic        clk_i, srst_i, carrier_detect_i, sclk, ss_n, mosi, miso, oe_n;
  logic        mute, byp, pd_o, acq, de, la_o;
  logic [1:0]  sw, off, lvl;
  logic [31:0] x, r;
  int          gc, od, la, car, pulses, seen, num_errors, n_checks;
  // The idle data line floats, so a stray read while deselected shows unknown.
  wire logic   miso_w = oe_n ? 1'bz : miso;
  equalizer_control_registers equalizer_control_registers_i (.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk),
    .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(oe_n), .carrier_detect_i(carrier_detect_i),
    .mute_o(mute), .bypass_o(byp), .power_down_o(pd_o), .acq_restart_o(acq), .output_swing_voltage_o(sw),
    .output_offset_voltage_o(off), .deemph_enable_o(de), .deemph_level_o(lvl), .launch_atten_opt_o(la_o));
  spi_host_model host_i (.clk_i(clk_i), .miso_i(miso_w), .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi));
  // ****************
  // Helpers
  // ****************
  // Clock, restart-pulse counter and hang guard.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (!srst_i && acq) seen++;
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Model writes: master reset wins, read-only bits are dropped.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    host_i.xfer({1'b0, a, d}, v);
    if (a == 0 && d[1]) begin
      gc = 2;
      od = 8'ha2;
      la = 8'h68;
    end else if (a == 0) gc = d[6:2];
    else if (a == 1) od = d & 8'hfe;
    else if (a == 2) la = d;
    if (a == 0 && d[1:0] != 0) pulses++;
  endtask
  task automatic rd_all();
    logic [7:0] v;
    for (int a = 0; a < 4; a++) begin
      host_i.xfer({1'b1, a[6:0], 8'h00}, v);
      chk(v, a == 0 ? {car[0], gc[4:0], 2'b00} : a == 1 ? od[7:0] : a == 2 ? la[7:0] : 8'h00);
    end
  endtask
  task automatic outs();
    logic p;
    p = (gc[2:1] == 2) || (gc[2:1] != 0 && car == 0);
    chk({4'h0, pd_o, mute, byp, la_o}, {4'h0, p, gc[4] & !p, gc[3] & !gc[4] & !p, la[7]});
    chk({sw, off, de, lvl, 1'b0}, od[7:0]);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence: defaults, every control code against both carrier states, restarts.
  initial begin
    {x, num_errors, n_checks, pulses, car} = {32'd5947, 128'd0};
    {gc, od, la, srst_i, carrier_detect_i} = {32'd2, 32'ha2, 32'h68, 2'b10};
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    seen = 0;
    rd_all();
    outs();
    for (int i = 0; i < 32; i++) begin
      car = i / 16;
      carrier_detect_i = car[0];
      r = rnd();
      wr(7'h00, {r[7], i[3:0], 3'h0});
      wr(7'h01, r[15:8]);
      wr(7'h02, {r[16], 7'h68});
      rd_all();
      outs();
    end
    wr(7'h00, 8'h51);
    wr(7'h03, r[23:16]);
    rd_all();
    wr(7'h00, 8'h02);
    rd_all();
    outs();
    chk(seen[7:0], pulses[7:0]);
    end_of_test();
  end
endmodule
bind equalizer_control_registers equalizer_control_registers_assertions equalizer_control_registers_assertions_i (
  .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .ss_n_i(ss_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
  .miso_oe_n_o(miso_oe_n_o), .carrier_detect_i(carrier_detect_i), .mute_o(mute_o), .bypass_o(bypass_o),
  .power_down_o(power_down_o), .acq_restart_o(acq_restart_o), .output_swing_voltage_o(output_swing_voltage_o),
  .output_offset_voltage_o(output_offset_voltage_o), .deemph_enable_o(deemph_enable_o),
  .deemph_level_o(deemph_level_o), .launch_atten_opt_o(launch_atten_opt_o));
`default_nettype wire
